// >>> rtl/fmcp_pkg.sv
package fmcp_pkg;

    // ****************************************
    // Clock and timing
    // ****************************************
    localparam int unsigned CLK_PERIOD_NS = 100;
    localparam int unsigned SYNC_STAGES   = 2;
    // Recovery after an aborted write is much longer than any other
    localparam int unsigned RECOV_OTHER_NS  = 40000;
    localparam int unsigned RECOV_WRITE_NS  = 12000000;
    localparam int unsigned RECOV_OTHER_CYC =
        (RECOV_OTHER_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECOV_WRITE_CYC =
        (RECOV_WRITE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
    localparam int unsigned RECOV_CNT_W = 18;

    // ****************************************
    // Opcodes
    // ****************************************
    localparam logic [7:0] OP_FAIL_CLEAR  = 8'h30;
    localparam logic [7:0] OP_BUSY_OUT_EN = 8'h70;
    localparam logic [7:0] OP_BUSY_OUT_DIS = 8'h80;
    localparam logic [7:0] OP_NO_OP       = 8'h00;
    localparam logic [7:0] OP_RESET_ARM   = 8'h66;
    localparam logic [7:0] OP_RESET       = 8'h99;
    localparam logic [7:0] OP_PARAM_READ  = 8'h5A;

    // ****************************************
    // Frame layout
    // ****************************************
    localparam logic [2:0] BIT_LAST      = 3'h7;
    localparam logic [2:0] BYTE_OPCODE   = 3'h0;
    localparam logic [2:0] BYTE_SINGLE   = 3'h1;
    localparam logic [2:0] BYTE_ADDR_LO  = 3'h1;
    localparam logic [2:0] BYTE_ADDR_HI  = 3'h3;
    localparam logic [2:0] BYTE_DUMMY    = 3'h4;
    localparam logic [2:0] BYTE_CNT_MAX  = 3'h5;

    // ****************************************
    // Parameter header space
    // ****************************************
    // Arbitrary value, not any real maker code
    localparam logic [7:0]  VENDOR_ID    = 8'hA5;
    localparam logic [7:0]  UNUSED_BYTE  = 8'hFF;
    localparam logic [4:0]  HDR_LAST_IDX = 5'h17;
    localparam logic [0:23][7:0] HDR_BYTES = {
        8'h53, 8'h46, 8'h44, 8'h50,        // 00h signature
        8'h00, 8'h01, 8'h01, UNUSED_BYTE,  // 04h revs, header count
        8'h00, 8'h00, 8'h01, 8'h09,        // 08h first header
        8'h30, 8'h00, 8'h00, UNUSED_BYTE,  // 0Ch table pointer
        VENDOR_ID, 8'h00, 8'h01, 8'h04,    // 10h second header
        8'h60, 8'h00, 8'h00, UNUSED_BYTE   // 14h table pointer
    };

endpackage

// >>> rtl/fmcp_sync.sv
`timescale 1ns/1ps
`default_nettype none

module fmcp_sync #(
    parameter int unsigned     W       = 1,
    parameter logic [W-1:0]    RST_VAL = '0
) (
    input  wire logic          clock_i,
    input  wire logic          arst_n_i,
    input  wire logic [W-1:0]  async_i,
    output logic      [W-1:0]  sync_o
);

    logic [W-1:0] meta_q;

    // First stage feeds only the second
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_q <= RST_VAL;
            sync_o <= RST_VAL;
        end else begin
            meta_q <= async_i;
            sync_o <= meta_q;
        end
    end

endmodule

`default_nettype wire

// >>> rtl/fmcp_hdr_rom.sv
`timescale 1ns/1ps
`default_nettype none

module fmcp_hdr_rom (
    input  wire logic [23:0] addr_i,
    output logic      [7:0]  data_o
);

    // Table body beyond the headers is not held here; reads as erased
    wire       hit = (addr_i[23:5] == 19'h00000) && (addr_i[4:0] <= fmcp_pkg::HDR_LAST_IDX);
    wire [4:0] idx = addr_i[4:0];

    assign data_o = hit ? fmcp_pkg::HDR_BYTES[idx] : fmcp_pkg::UNUSED_BYTE;

endmodule

`default_nettype wire

// >>> rtl/fmcp_top.sv
// Summary of operation
// - Fail-flag clear command zeroes both program and erase fail flags.
// - Single-byte commands run only if chip select rises on a byte boundary.
// - Busy-output enable puts ready/busy on serial output in continuous program.
// - Busy-output disable cancels that and stops ready/busy on serial output.
// - No-operation only cancels a pending reset arm.
// - Software reset is arm frame 66h then reset frame 99h.
// - Any command other than reset or a repeated arm after an arm disarms it.
// - Software reset returns standby, single-line mode, volatile defaults.
// - Reset during program or erase aborts it; data may corrupt.
// - Recovery after an aborted write is longer than otherwise.
// - Parameter read: 5Ah, three address bytes, one dummy, then data out.
// - Header reports minor revision 00h at 04h, major 01h at 05h.
// - Byte 06h holds header count minus one, 01h.
// - First header at 08h: ID 00h, rev 1.0, 09h dwords, pointer 30h.
// - Second header at 10h: vendor ID, rev 1.0, 04h dwords, pointer 60h.
// - Unused header bytes 07h, 0Fh, 17h always read FFh.
// - Fail flags volatile, read-only, one means last operation failed, default zero.
// - Continuous program indicator volatile, read-only, one while active, default zero.
`timescale 1ns/1ps
`default_nettype none

module fmcp_top #(
    parameter int unsigned RECOV_WRITE_CYC = fmcp_pkg::RECOV_WRITE_CYC,
    parameter int unsigned RECOV_OTHER_CYC = fmcp_pkg::RECOV_OTHER_CYC
) (
    input  wire logic clock_i,
    input  wire logic arst_n_i,
    // Serial link pins
    input  wire logic cs_n_i,
    input  wire logic sclk_i,
    input  wire logic si_i,
    output logic      so_o,
    output logic      so_oe_o,
    // Array engine side, same clock
    input  wire logic prog_fail_set_i,
    input  wire logic erase_fail_set_i,
    input  wire logic write_busy_i,
    input  wire logic continuous_program_mode_i,
    // Status and control
    output logic      prog_fail_o,
    output logic      erase_fail_o,
    output logic      continuous_program_mode_o,
    output logic      busy_output_en_o,
    output logic      reset_armed_o,
    output logic      soft_reset_o,
    output logic      write_abort_o,
    output logic      reset_busy_o
);

    // ****************************************
    // Pin synchronisers
    // ****************************************
    logic [2:0] pins_s;

    // Reset values match idle pins, so no false edge follows reset
    fmcp_sync #(
        .W       (3),
        .RST_VAL (3'h4)
    ) u_sync (
        .clock_i  (clock_i),
        .arst_n_i (arst_n_i),
        .async_i  ({cs_n_i, sclk_i, si_i}),
        .sync_o   (pins_s)
    );

    wire cs_n_s = pins_s[2];
    wire sclk_s = pins_s[1];
    wire si_s   = pins_s[0];

    // ****************************************
    // State
    // ****************************************
    logic                              cs_prev_q;
    logic                              sclk_prev_q;
    logic [2:0]                        bit_cnt_q;
    logic [2:0]                        byte_cnt_q;
    logic [6:0]                        sh_in_q;
    logic [7:0]                        opcode_q;
    logic [23:0]                       addr_q;
    logic [7:0]                        out_sh_q;
    logic                              rd_out_q;
    logic                              armed_q;
    logic [fmcp_pkg::RECOV_CNT_W-1:0]  rcv_cnt_q;
    logic [fmcp_pkg::RECOV_CNT_W-1:0]  rcv_cnt_d;
    logic [7:0]                        rom_data;

    // ****************************************
    // Edge and byte decode
    // ****************************************
    wire sclk_rise  = sclk_s & ~sclk_prev_q & ~cs_n_s;
    wire sclk_fall  = ~sclk_s & sclk_prev_q & ~cs_n_s;
    wire cs_rise    = cs_n_s & ~cs_prev_q;
    wire byte_done  = sclk_rise & (bit_cnt_q == fmcp_pkg::BIT_LAST);
    wire [7:0] byte_in = {sh_in_q, si_s};
    wire recovering = (rcv_cnt_q != '0);

    wire [7:0] op_now = (byte_cnt_q == fmcp_pkg::BYTE_OPCODE) ? byte_in : opcode_q;
    wire is_read    = (op_now == fmcp_pkg::OP_PARAM_READ) & ~recovering;
    wire addr_byte  = (byte_cnt_q >= fmcp_pkg::BYTE_ADDR_LO)
                    & (byte_cnt_q <= fmcp_pkg::BYTE_ADDR_HI);
    wire take_addr  = byte_done & is_read & addr_byte;
    wire load_out   = byte_done & is_read & (byte_cnt_q >= fmcp_pkg::BYTE_DUMMY);

    // Frame ends: a command counts only with its opcode byte fully in
    wire any_cmd    = cs_rise & (byte_cnt_q != '0) & ~recovering;
    // A second full byte refuses the command as well
    wire on_bound   = (byte_cnt_q == fmcp_pkg::BYTE_SINGLE) & (bit_cnt_q == '0);
    wire cmd_ok     = any_cmd & on_bound;

    wire do_clear   = cmd_ok & (opcode_q == fmcp_pkg::OP_FAIL_CLEAR);
    wire do_ben     = cmd_ok & (opcode_q == fmcp_pkg::OP_BUSY_OUT_EN);
    wire do_bdis    = cmd_ok & (opcode_q == fmcp_pkg::OP_BUSY_OUT_DIS);
    wire do_arm     = cmd_ok & (opcode_q == fmcp_pkg::OP_RESET_ARM);
    wire do_rst     = cmd_ok & (opcode_q == fmcp_pkg::OP_RESET) & armed_q;

    // Ready/busy only drives the line while no table data is going out
    wire ready_out  = continuous_program_mode_o & busy_output_en_o
                    & ~cs_n_s & ~rd_out_q;

    // Soft reset returns the fail flags to their defaults too
    wire flag_clear = do_clear | do_rst;

    // Released as soon as chip select rises, so no stale bit is driven
    wire so_drive   = (rd_out_q & ~cs_n_s) | ready_out;

    // ****************************************
    // Header lookup
    // ****************************************
    fmcp_hdr_rom u_rom (
        .addr_i (addr_q),
        .data_o (rom_data)
    );

    // ****************************************
    // Recovery counter
    // ****************************************
    // Longer wait only when a program or erase was really cut off
    always_comb begin
        rcv_cnt_d = rcv_cnt_q;
        if (do_rst) begin
            if (write_busy_i) begin
                rcv_cnt_d = fmcp_pkg::RECOV_CNT_W'(RECOV_WRITE_CYC);
            end else begin
                rcv_cnt_d = fmcp_pkg::RECOV_CNT_W'(RECOV_OTHER_CYC);
            end
        end else if (recovering) begin
            rcv_cnt_d = rcv_cnt_q - 1'b1;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rcv_cnt_q    <= '0;
            reset_busy_o <= 1'b0;
        end else begin
            rcv_cnt_q    <= rcv_cnt_d;
            reset_busy_o <= (rcv_cnt_d != '0);
        end
    end

    // ****************************************
    // Frame shifter
    // ****************************************
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            cs_prev_q   <= 1'b1;
            sclk_prev_q <= 1'b0;
        end else begin
            cs_prev_q   <= cs_n_s;
            sclk_prev_q <= sclk_s;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            bit_cnt_q  <= '0;
            byte_cnt_q <= '0;
            sh_in_q    <= '0;
        end else if (cs_n_s) begin
            bit_cnt_q  <= '0;
            byte_cnt_q <= '0;
        end else if (sclk_rise) begin
            bit_cnt_q <= bit_cnt_q + 1'b1;
            sh_in_q   <= byte_in[6:0];
            // Saturates, so every later byte of a long read reloads
            if (byte_done && byte_cnt_q != fmcp_pkg::BYTE_CNT_MAX) begin
                byte_cnt_q <= byte_cnt_q + 1'b1;
            end
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            opcode_q <= fmcp_pkg::OP_NO_OP;
        end else if (byte_done && byte_cnt_q == fmcp_pkg::BYTE_OPCODE) begin
            opcode_q <= byte_in;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            addr_q <= '0;
        end else if (take_addr) begin
            addr_q <= {addr_q[15:0], byte_in};
        end else if (load_out) begin
            addr_q <= addr_q + 24'h000001;
        end
    end

    // ****************************************
    // Table output
    // ****************************************
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            out_sh_q <= '0;
            rd_out_q <= 1'b0;
        end else if (cs_n_s) begin
            rd_out_q <= 1'b0;
        end else if (load_out) begin
            out_sh_q <= rom_data;
            rd_out_q <= 1'b1;
        end else if (sclk_fall) begin
            out_sh_q <= {out_sh_q[6:0], 1'b0};
        end
    end

    // Data changes on the falling edge so it is settled by the next rise
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            so_o    <= 1'b0;
            so_oe_o <= 1'b0;
        end else begin
            so_oe_o <= so_drive;
            if (rd_out_q && sclk_fall) begin
                so_o <= out_sh_q[7];
            end else if (ready_out) begin
                so_o <= ~write_busy_i;
            end
        end
    end

    // ****************************************
    // Command effects
    // ****************************************
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            armed_q       <= 1'b0;
            reset_armed_o <= 1'b0;
        end else if (any_cmd) begin
            // No-op, bad frames with a full opcode byte and everything else disarm
            armed_q       <= do_arm;
            reset_armed_o <= do_arm;
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            busy_output_en_o <= 1'b0;
        end else if (do_rst || do_bdis) begin
            busy_output_en_o <= 1'b0;
        end else if (do_ben) begin
            busy_output_en_o <= 1'b1;
        end
    end

    // A failure reported in the clearing cycle survives the clear
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            prog_fail_o  <= 1'b0;
            erase_fail_o <= 1'b0;
        end else begin
            prog_fail_o  <= prog_fail_set_i
                          | (prog_fail_o & ~flag_clear);
            erase_fail_o <= erase_fail_set_i
                          | (erase_fail_o & ~flag_clear);
        end
    end

    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            continuous_program_mode_o <= 1'b0;
        end else begin
            continuous_program_mode_o <= continuous_program_mode_i & ~do_rst;
        end
    end

    // Pulses tell the array engine to stop and fall back to standby
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            soft_reset_o  <= 1'b0;
            write_abort_o <= 1'b0;
        end else begin
            soft_reset_o  <= do_rst;
            write_abort_o <= do_rst & write_busy_i;
        end
    end

endmodule

`default_nettype wire

// >>> verification/fmcp_monitor.sv
`timescale 1ns/1ps
`default_nettype none

module fmcp_monitor #(
    parameter int unsigned RECOV_WRITE_CYC = 20,
    parameter int unsigned RECOV_OTHER_CYC = 4
) (
    input wire logic clock_i,
    input wire logic arst_n_i,
    input wire logic cs_n_i,
    input wire logic prog_fail_set_i,
    input wire logic continuous_program_mode_i,
    input wire logic so_oe_o,
    input wire logic prog_fail_o,
    input wire logic continuous_program_mode_o,
    input wire logic busy_output_en_o,
    input wire logic reset_armed_o,
    input wire logic soft_reset_o,
    input wire logic write_abort_o,
    input wire logic reset_busy_o
);
    logic [31:0] run_q;
    logic        aborted_q;

    default clocking @(posedge clock_i);
    endclocking
    default disable iff (!arst_n_i);

    // Length of the current recovery and whether it followed an abort
    always_ff @(posedge clock_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            run_q <= '0;
            aborted_q <= 1'b0;
        end else begin
            run_q <= reset_busy_o ? run_q + 32'h1 : 32'h0;
            aborted_q <= write_abort_o | (aborted_q & ~soft_reset_o);
        end
    end

    abort_with_reset_a: assert property (write_abort_o |-> soft_reset_o)
        else $error("abort pulse without software reset");
    reset_needs_arm_a: assert property (soft_reset_o |-> $past(reset_armed_o))
        else $error("software reset without pending arm");
    reset_clears_a: assert property (soft_reset_o |=> !busy_output_en_o && !reset_armed_o)
        else $error("software reset left volatile state set");
    recov_start_a: assert property (soft_reset_o |-> ##[0:1] reset_busy_o)
        else $error("recovery did not start");
    recov_len_a: assert property ($fell(reset_busy_o) |->
        run_q == (aborted_q ? RECOV_WRITE_CYC : RECOV_OTHER_CYC))
        else $error("recovery length wrong");
    fail_cause_a: assert property ($rose(prog_fail_o) |->
        $past(prog_fail_set_i) || $past(prog_fail_set_i, 2))
        else $error("fail flag rose without cause");
    fail_clear_end_a: assert property ($fell(prog_fail_o) |-> cs_n_i && $past(cs_n_i, 2))
        else $error("fail flag cleared inside a frame");
    continuous_program_mode_copy_a: assert property ($past(arst_n_i)
        && !soft_reset_o && !$past(soft_reset_o)
        |-> continuous_program_mode_o == $past(continuous_program_mode_i))
        else $error("mode indicator does not follow");
    oe_release_a: assert property (cs_n_i [*6] |-> !so_oe_o)
        else $error("output still driven while deselected");
    frozen_recov_a: assert property (reset_busy_o && $past(reset_busy_o) |->
        $stable(busy_output_en_o) && $stable(reset_armed_o))
        else $error("command taken during recovery");

    c_reset_c: cover property (soft_reset_o);
    c_abort_c: cover property (write_abort_o);
    c_drive_c: cover property (so_oe_o && !cs_n_i);
endmodule

bind fmcp_top fmcp_monitor #(
    .RECOV_WRITE_CYC(RECOV_WRITE_CYC),
    .RECOV_OTHER_CYC(RECOV_OTHER_CYC)
) mon (.clock_i, .arst_n_i, .cs_n_i, .prog_fail_set_i, .continuous_program_mode_i,
    .so_oe_o, .prog_fail_o, .continuous_program_mode_o, .busy_output_en_o,
    .reset_armed_o, .soft_reset_o, .write_abort_o, .reset_busy_o);

`default_nettype wire

// >>> verification/fmcp_host.sv
`timescale 1ns/1ps
`default_nettype none

module fmcp_host (
    input  wire logic clock_i,
    input  wire logic so_i,
    output logic      cs_n_o,
    output logic      sclk_o,
    output logic      si_o
);
    initial begin
        cs_n_o = 1'b1;
        sclk_o = 1'b0;
        si_o = 1'b0;
    end

    task automatic start();
        cs_n_o = 1'b0;
    endtask

    // MSB first, data set at the fall and taken at the rise
    task automatic shift(input logic [7:0] tx, input int n, output logic [7:0] rx);
        rx = 8'h00;
        for (int i = 7; i > 7 - n; i--) begin
            si_o = tx[i];
            repeat (4) @(negedge clock_i);
            sclk_o = 1'b1;
            rx = {rx[6:0], so_i};
            repeat (4) @(negedge clock_i);
            sclk_o = 1'b0;
        end
    endtask

    // Data line flips on release so a stale level is never trusted
    task automatic stop();
        repeat (4) @(negedge clock_i);
        cs_n_o = 1'b1;
        si_o = ~si_o;
        repeat (12) @(negedge clock_i);
    endtask
endmodule

`default_nettype wire

// >>> verification/test_flash_misc_command_and_param_read.sv
`timescale 1ns/1ps
`default_nettype none

module test_flash_misc_command_and_param_read;
    localparam int unsigned RW = 200;
    localparam int unsigned RO = 4;
    logic       clock_i = 1'b0;
    logic       arst_n_i = 1'b0;
    logic       cs_n_i, sclk_i, si_i, so_o, so_oe_o;
    logic       prog_fail_set_i = 1'b0;
    logic       erase_fail_set_i = 1'b0;
    logic       write_busy_i = 1'b0;
    logic       continuous_program_mode_i = 1'b0;
    logic       prog_fail_o, erase_fail_o, continuous_program_mode_o, busy_output_en_o;
    logic       reset_armed_o, soft_reset_o, write_abort_o, reset_busy_o;
    logic [7:0] rx;
    logic [7:0] status;
    int         fail_count = 0;
    int         comparisons = 0;
    int         n_srst = 0;
    int         n_abort = 0;
    // Fields: set fail flags first, opcode, bit count, expected {prog, erase, enable, armed}
    logic [19:0] rows [11] = '{
        20'h1307C,
        20'h03080,
        20'h07082,
        20'h1808C,
        20'h0708E,
        20'h0668F,
        20'h0008E,
        20'h0668F,
        20'h03082,
        20'h06683,
        20'h09980
    };
    logic [7:0] tab [24] = '{8'h53, 8'h46, 8'h44, 8'h50, 8'h00, 8'h01, 8'h01, 8'hFF,
        8'h00, 8'h00, 8'h01, 8'h09, 8'h30, 8'h00, 8'h00, 8'hFF,
        fmcp_pkg::VENDOR_ID, 8'h00, 8'h01, 8'h04, 8'h60, 8'h00, 8'h00, 8'hFF};

    assign status = {prog_fail_o, erase_fail_o, continuous_program_mode_o, busy_output_en_o,
                     reset_armed_o, soft_reset_o, reset_busy_o, so_oe_o};

    // Undriven line shows the inverse, so a read without enable fails
    wire        so_line = so_oe_o ? so_o : ~so_o;

    always #50 clock_i = ~clock_i;

    // Pulses last a full cycle, so one look per cycle counts each once
    always @(negedge clock_i) begin
        if (soft_reset_o === 1'b1) n_srst++;
        if (write_abort_o === 1'b1) n_abort++;
    end

    fmcp_top #(.RECOV_WRITE_CYC(RW), .RECOV_OTHER_CYC(RO)) dut (
        .clock_i, .arst_n_i, .cs_n_i, .sclk_i, .si_i, .so_o, .so_oe_o,
        .prog_fail_set_i, .erase_fail_set_i, .write_busy_i, .continuous_program_mode_i,
        .prog_fail_o, .erase_fail_o, .continuous_program_mode_o, .busy_output_en_o,
        .reset_armed_o, .soft_reset_o, .write_abort_o, .reset_busy_o);

    fmcp_host host (.clock_i, .so_i(so_line), .cs_n_o(cs_n_i), .sclk_o(sclk_i), .si_o(si_i));

    task automatic check(input logic [7:0] got, input logic [7:0] exp);
        comparisons++;
        if (got !== exp) begin
            fail_count++;
            $display("unexpected at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic frame(input logic [7:0] op, input int n);
        host.start();
        host.shift(op, n, rx);
        host.stop();
    endtask

    task automatic open_read(input logic [7:0] a);
        logic [7:0] hdr [5];
        hdr = '{8'h5A, 8'h00, 8'h00, a, 8'h00};
        host.start();
        foreach (hdr[i]) host.shift(hdr[i], 8, rx);
    endtask

    task automatic report_and_stop();
        $display("comparisons %0d mismatches %0d", comparisons, fail_count);
        if (fail_count == 0 && comparisons > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask

    initial begin
        #(20000 * 100);
        fail_count++;
        report_and_stop();
    end

    initial begin
        repeat (12) @(negedge clock_i);
        arst_n_i = 1'b1;
        @(negedge clock_i);
        check(status, 8'h00);
        $display("reset test done");
        foreach (rows[i]) begin
            prog_fail_set_i = rows[i][16];
            erase_fail_set_i = rows[i][16];
            @(negedge clock_i);
            prog_fail_set_i = 1'b0;
            erase_fail_set_i = 1'b0;
            frame(rows[i][15:8], int'(rows[i][7:4]));
            check({4'h0, status[7:6], status[4:3]}, {4'h0, rows[i][3:0]});
        end
        check(n_srst[7:0], 8'h01);
        $display("command table done");
        frame(8'h70, 8);
        continuous_program_mode_i = 1'b1;
        write_busy_i = 1'b1;
        host.start();
        repeat (6) @(negedge clock_i);
        check({5'h0, continuous_program_mode_o, so_oe_o, so_o}, 8'h06);
        write_busy_i = 1'b0;
        repeat (3) @(negedge clock_i);
        check({6'h0, so_oe_o, so_o}, 8'h03);
        host.stop();
        frame(8'h80, 8);
        host.start();
        repeat (6) @(negedge clock_i);
        check({7'h0, so_oe_o}, 8'h00);
        host.stop();
        continuous_program_mode_i = 1'b0;
        $display("busy output test done");
        write_busy_i = 1'b1;
        frame(8'h66, 8);
        frame(8'h99, 8);
        write_busy_i = 1'b0;
        frame(8'h70, 8);
        check({6'h0, busy_output_en_o, reset_busy_o}, 8'h01);
        repeat (RW) @(negedge clock_i);
        check({n_abort[3:0], 3'h0, reset_busy_o}, 8'h10);
        $display("abort test done");
        open_read(8'h00);
        foreach (tab[i]) begin
            host.shift(8'hFF, 8, rx);
            check(rx, tab[i]);
        end
        host.stop();
        open_read(8'h16);
        host.shift(8'hFF, 8, rx);
        check(rx, 8'h00);
        host.shift(8'hFF, 4, rx);
        check(rx, 8'h0F);
        host.stop();
        check({7'h0, so_oe_o}, 8'h00);
        $display("table read test done");
        prog_fail_set_i = 1'b1;
        @(negedge clock_i);
        prog_fail_set_i = 1'b0;
        frame(8'h70, 8);
        frame(8'h66, 8);
        check({4'h0, status[7], status[4:3], status[0]}, 8'h0E);
        arst_n_i = 1'b0;
        repeat (2) @(negedge clock_i);
        arst_n_i = 1'b1;
        @(negedge clock_i);
        check(status, 8'h00);
        $display("mid-run reset test done");
        report_and_stop();
    end
endmodule

`default_nettype wire
